// ---- rtl/iic_map.svh ----
// Purpose: constants of the isolated input conditioner
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: definitions only
`ifndef IIC_MAP_SVH
`define IIC_MAP_SVH

// ============================================================
// timing
`define IIC_CLK_HZ 50000000
`define IIC_SCAN_MS 5
`define IIC_SCAN_CYC (`IIC_CLK_HZ / 1000 * `IIC_SCAN_MS)
`define IIC_AC_EXTRA_MS 30
`define IIC_AC_REL_PCT 10
`define IIC_MV_PER_STEP 100

// ============================================================
// global registers
`define IIC_A_STATE 12'h000
`define IIC_A_IRQ_STAT 12'h004
`define IIC_A_IRQ_MASK 12'h008
`define IIC_A_BASE_NUM 12'h00C
`define IIC_A_CH_FIRST 12'h040
`define IIC_A_CH_END 12'h140
`define IIC_CH_SHIFT 5

// ============================================================
// per-channel register offsets within a 32-byte slot
`define IIC_O_CTRL 5'h00
`define IIC_O_ON_LVL 5'h04
`define IIC_O_OFF_LVL 5'h08
`define IIC_O_ACT_DLY 5'h0C
`define IIC_O_DROP_DLY 5'h10
`define IIC_O_COUNT 5'h14
`define IIC_O_VOLT 5'h18

// ============================================================
// control fields, reset values and bus response codes
`define IIC_B_POL 0
`define IIC_B_AC 1
`define IIC_B_CLR 2
`define IIC_RST_POL 1'h0
`define IIC_RST_AC 1'h0
`define IIC_RST_ON 11'h370
`define IIC_RST_OFF 11'h258
`define IIC_RST_DLY 21'h000000
`define IIC_RESP_OK 2'h0
`define IIC_RESP_ERR 2'h2

`endif

// ---- rtl/iic_pkg.sv ----
// Purpose: types of the isolated input conditioner
// Assumes: AXI4-Lite register bus, 12-bit byte address
// Notes: channel voltages arrive in millivolts
package iic_pkg;
  localparam int unsigned IIC_NCH = 8;

  typedef logic [18:0] iic_mv_t;
  typedef logic [10:0] iic_lvl_t;
  typedef logic [20:0] iic_ms_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } iic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iic_axi_rsp_t;
endpackage

// ---- rtl/iic_top.sv ----
// Purpose: eight-channel isolated input conditioner with AXI4-Lite registers
// Assumes: voltages sampled synchronously, in millivolts; one clock
// Notes: each rule below is tagged at the logic that carries it out
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`include "iic_map.svh"

module iic_top #(
  parameter int unsigned SCAN_CYCLES = `IIC_SCAN_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire iic_pkg::iic_axi_req_t axi_req,
  output iic_pkg::iic_axi_rsp_t axi_rsp,
  input wire iic_pkg::iic_mv_t [7:0] channel_voltage_in,
  input wire logic [7:0] preceding_input_count,
  output logic [7:0] channel_state,
  output logic irq
);
  import iic_pkg::*;

  // ============================================================
  // scan timer
  logic [31:0] scan_cnt_r;
  logic scan_tick;

  // one tick every SCAN_CYCLES clocks; conditioning acts only on it
  assign scan_tick = (scan_cnt_r == 32'(SCAN_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scan_cnt_r <= 32'h0;
    end else if (scan_tick) begin
      scan_cnt_r <= 32'h0;
    end else begin
      scan_cnt_r <= scan_cnt_r + 32'h1;
    end
  end

  // ============================================================
  // bus write path
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wr_hit_ch;
  logic [11:0] wr_sub;
  logic [2:0] wr_ch;
  logic [4:0] wr_off;
  logic wr_glob_ok;
  logic wr_off_ok;

  // address and data may arrive in either order; the response waits for both
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_sub = aw_addr_r - `IIC_A_CH_FIRST;
  assign wr_ch = wr_sub[7:5];
  assign wr_off = wr_sub[4:0];
  assign wr_hit_ch = (aw_addr_r >= `IIC_A_CH_FIRST) && (aw_addr_r < `IIC_A_CH_END);
  assign wr_glob_ok = (aw_addr_r == `IIC_A_IRQ_STAT) || (aw_addr_r == `IIC_A_IRQ_MASK)
    || (aw_addr_r == `IIC_A_STATE) || (aw_addr_r == `IIC_A_BASE_NUM);
  // channel slots answer with an error on offsets that hold no register
  assign wr_off_ok = (wr_off == `IIC_O_CTRL) || (wr_off == `IIC_O_ON_LVL) || (wr_off == `IIC_O_OFF_LVL)
    || (wr_off == `IIC_O_ACT_DLY) || (wr_off == `IIC_O_DROP_DLY) || (wr_off == `IIC_O_COUNT)
    || (wr_off == `IIC_O_VOLT);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `IIC_RESP_OK;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= ((wr_hit_ch && wr_off_ok) || wr_glob_ok) ? `IIC_RESP_OK : `IIC_RESP_ERR;
      end else if (bvalid_r && axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // per-channel settings, conditioning and counters
  logic pol_r [8];
  logic ac_r [8];
  iic_lvl_t on_r [8];
  iic_lvl_t off_r [8];
  iic_ms_t act_dly_r [8];
  iic_ms_t drop_dly_r [8];
  logic [31:0] count_r [8];
  iic_mv_t volt_r [8];
  logic [7:0] state_r;
  logic [7:0] rise_ev;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic wr_me;
      logic [31:0] wv;
      logic energized_r;
      logic energized_nxt;
      logic target;
      logic [21:0] elapsed_r;
      logic [21:0] need;
      logic [18:0] on_mv;
      logic [18:0] off_mv;
      logic clr_me;

      assign wr_me = wr_fire && wr_hit_ch && (wr_ch == 3'(g));
      assign clr_me = wr_me && (wr_off == `IIC_O_CTRL) && wv[`IIC_B_CLR];
      assign on_mv = 19'(on_r[g] * `IIC_MV_PER_STEP);
      // AC mode: release level a fixed fraction of the activation level
      assign off_mv = ac_r[g] ? 19'(on_r[g] * (`IIC_MV_PER_STEP * `IIC_AC_REL_PCT / 100))
        : 19'(off_r[g] * `IIC_MV_PER_STEP);

      always_comb begin
        wv = 32'h0;
        unique case (wr_off)
          `IIC_O_CTRL: wv = merge({29'h0, 1'b0, ac_r[g], pol_r[g]}, w_data_r, w_strb_r);
          `IIC_O_ON_LVL: wv = merge({21'h0, on_r[g]}, w_data_r, w_strb_r);
          `IIC_O_OFF_LVL: wv = merge({21'h0, off_r[g]}, w_data_r, w_strb_r);
          `IIC_O_ACT_DLY: wv = merge({11'h0, act_dly_r[g]}, w_data_r, w_strb_r);
          `IIC_O_DROP_DLY: wv = merge({11'h0, drop_dly_r[g]}, w_data_r, w_strb_r);
          default: wv = 32'h0;
        endcase
      end

      always_ff @(posedge clk) begin
        if (!resetn) begin
          pol_r[g] <= `IIC_RST_POL;
          ac_r[g] <= `IIC_RST_AC;
          on_r[g] <= `IIC_RST_ON;
          off_r[g] <= `IIC_RST_OFF;
          act_dly_r[g] <= `IIC_RST_DLY;
          drop_dly_r[g] <= `IIC_RST_DLY;
        end else if (wr_me) begin
          // each channel keeps its own copy of every setting
          unique case (wr_off)
            `IIC_O_CTRL: begin
              pol_r[g] <= wv[`IIC_B_POL];
              ac_r[g] <= wv[`IIC_B_AC];
            end
            `IIC_O_ON_LVL: on_r[g] <= wv[10:0];
            `IIC_O_OFF_LVL: off_r[g] <= wv[10:0];
            `IIC_O_ACT_DLY: act_dly_r[g] <= wv[20:0];
            `IIC_O_DROP_DLY: drop_dly_r[g] <= wv[20:0];
            default: ;
          endcase
        end
      end

      // hysteresis on the energized level
      always_comb begin
        energized_nxt = energized_r;
        if (channel_voltage_in[g] > on_mv) begin
          energized_nxt = 1'b1;
        end else if (channel_voltage_in[g] < off_mv) begin
          energized_nxt = 1'b0;
        end
      end

      assign target = energized_nxt ^ pol_r[g];
      // elapsed counts ms in whole scans and restarts whenever target equals state
      assign need = target ? {1'b0, act_dly_r[g]}
        : ({1'b0, drop_dly_r[g]} + (ac_r[g] ? 22'(`IIC_AC_EXTRA_MS) : 22'h0));

      always_ff @(posedge clk) begin
        if (!resetn) begin
          energized_r <= 1'b0;
          state_r[g] <= 1'b0;
          elapsed_r <= 22'h0;
          volt_r[g] <= 19'h0;
        end else if (scan_tick) begin
          volt_r[g] <= channel_voltage_in[g];
          energized_r <= energized_nxt;
          if (target == state_r[g]) begin
            elapsed_r <= 22'h0;
          end else if (elapsed_r >= need) begin
            state_r[g] <= target;
            elapsed_r <= 22'h0;
          end else begin
            elapsed_r <= elapsed_r + 22'(`IIC_SCAN_MS);
          end
        end
      end

      assign rise_ev[g] = scan_tick && (target != state_r[g]) && (elapsed_r >= need) && target;

      // an increment in the clearing cycle still counts
      always_ff @(posedge clk) begin
        if (!resetn) begin
          count_r[g] <= 32'h0;
        end else if (rise_ev[g]) begin
          count_r[g] <= clr_me ? 32'h1 : count_r[g] + 32'h1;
        end else if (clr_me) begin
          count_r[g] <= 32'h0;
        end
      end
    end
  endgenerate

  assign channel_state = state_r;

  // ============================================================
  // interrupts
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic [31:0] glob_wv;
  logic [7:0] w1c;
  logic [31:0] mask_wv;

  assign glob_wv = merge(32'h0, w_data_r, w_strb_r);
  assign w1c = (wr_fire && aw_addr_r == `IIC_A_IRQ_STAT) ? glob_wv[7:0] : 8'h00;
  assign mask_wv = merge({24'h0, irq_mask_r}, w_data_r, w_strb_r);

  // a rise in the clearing cycle wins over the write-one-to-clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_stat_r <= 8'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | rise_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_mask_r <= 8'h00;
    end else if (wr_fire && aw_addr_r == `IIC_A_IRQ_MASK) begin
      irq_mask_r <= mask_wv[7:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ============================================================
  // bus read path
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [11:0] rd_sub;
  logic [2:0] rd_ch;

  // read data is captured from the live registers as the address is taken
  assign rd_sub = axi_req.araddr - `IIC_A_CH_FIRST;
  assign rd_ch = rd_sub[7:5];

  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    if ((axi_req.araddr >= `IIC_A_CH_FIRST) && (axi_req.araddr < `IIC_A_CH_END)) begin
      unique case (rd_sub[4:0])
        `IIC_O_CTRL: rd_val = {30'h0, ac_r[rd_ch], pol_r[rd_ch]};
        `IIC_O_ON_LVL: rd_val = {21'h0, on_r[rd_ch]};
        `IIC_O_OFF_LVL: rd_val = {21'h0, off_r[rd_ch]};
        `IIC_O_ACT_DLY: rd_val = {11'h0, act_dly_r[rd_ch]};
        `IIC_O_DROP_DLY: rd_val = {11'h0, drop_dly_r[rd_ch]};
        `IIC_O_COUNT: rd_val = count_r[rd_ch];
        `IIC_O_VOLT: rd_val = {13'h0, volt_r[rd_ch]};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      unique case (axi_req.araddr)
        `IIC_A_STATE: rd_val = {24'h0, state_r};
        `IIC_A_IRQ_STAT: rd_val = {24'h0, irq_stat_r};
        `IIC_A_IRQ_MASK: rd_val = {24'h0, irq_mask_r};
        `IIC_A_BASE_NUM: rd_val = {24'h0, preceding_input_count};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `IIC_RESP_OK;
    end else if (axi_req.arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? `IIC_RESP_OK : `IIC_RESP_ERR;
    end else if (rvalid_r && axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp.awready = !aw_hold_r && !bvalid_r;
    axi_rsp.wready = !w_hold_r && !bvalid_r;
    axi_rsp.bvalid = bvalid_r;
    axi_rsp.bresp = bresp_r;
    axi_rsp.arready = !rvalid_r;
    axi_rsp.rvalid = rvalid_r;
    axi_rsp.rdata = rdata_r;
    axi_rsp.rresp = rresp_r;
  end
endmodule

// ---- bench/iic_field.sv ----
// Purpose: field wiring as seen through the measurement front end
// Assumes: bench sets a target voltage per channel in millivolts
// Notes: output follows the target one clock later
module iic_field (
  input wire logic clk,
  input wire iic_pkg::iic_mv_t [7:0] target_mv,
  output iic_pkg::iic_mv_t [7:0] volt_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  import iic_pkg::*;
  // one sample per clock, held between changes
  always_ff @(posedge clk) volt_mv <= target_mv;
endmodule

// ---- bench/iic_properties.sv ----
// Purpose: bus and scan checks of iic_top
// Assumes: bound to the iic_top ports
// Notes: scan phase is mirrored by a counter reset together with the design
module iic_props #(
  parameter int unsigned SCAN_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire iic_pkg::iic_axi_req_t axi_req,
  input wire iic_pkg::iic_axi_rsp_t axi_rsp,
  input wire iic_pkg::iic_mv_t [7:0] channel_voltage_in,
  input wire logic [7:0] preceding_input_count,
  input wire logic [7:0] channel_state,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import iic_pkg::*;
  // ============================================================
  // scan phase and bus steps
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  int unsigned cnt_r;
  always_ff @(posedge clk) cnt_r <= (!resetn || cnt_r == SCAN_CYCLES - 1) ? 0 : cnt_r + 1;
  sequence s_wr;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  AST_SCAN: assert property (!$stable(channel_state) |-> cnt_r == 0)
    else $error("state changed off the scan tick");
  AST_WR_LAT: assert property (s_wr |-> ##2 axi_rsp.bvalid)
    else $error("write response not on time");
  AST_RD_LAT: assert property (s_rd |=> axi_rsp.rvalid)
    else $error("read data not on time");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  AST_B_DROP: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read data repeated");
  AST_AR_BLOCK: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while data pending");
  AST_AW_BLOCK: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  AST_R_CAUSE: assert property ($rose(axi_rsp.rvalid) |-> $past(axi_req.arvalid) && $past(axi_rsp.arready))
    else $error("read data without request");
endmodule

// ---- bench/iic_top_tb_top.sv ----
// Purpose: register level tests of iic_top
// Assumes: short scan of 20 clocks
// Notes: state checks read the value settled before the last edge
module iic_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iic_pkg::*;
  localparam int SC = 20;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  iic_axi_req_t req = '0;
  iic_axi_rsp_t rsp;
  iic_mv_t [7:0] tgt = '0;
  iic_mv_t [7:0] vin;
  logic [7:0] st;
  logic irq;
  logic [31:0] d;
  logic [1:0] rr;
  logic [11:0] b;
  logic [7:0] pre = 8'h03;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  iic_field i_iic_field (.clk(clk), .target_mv(tgt), .volt_mv(vin));
  iic_top #(.SCAN_CYCLES(SC)) i_iic_top (.clk(clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
    .channel_voltage_in(vin), .preceding_input_count(pre), .channel_state(st), .irq(irq));
  initial forever #10 clk = ~clk;
  // ============================================================
  // tasks
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (!rsp.bvalid);
    chk("bresp", 32'h0, 32'(rsp.bresp));
    req.bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'h0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
    chk("rresp", 32'h0, 32'(rr));
  endtask
  task automatic scans(input int n);
    repeat (n * SC) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ============================================================
  // tests
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    chk("state", 32'h0, 32'(st));
    for (int i = 0; i < 8; i++) begin
      b = 12'h040 + 12'(i * 32);
      rc("ctrl", b, 32'h0);
      rc("on", b + 12'h004, 32'h370);
      rc("off", b + 12'h008, 32'h258);
      rc("act", b + 12'h00C, 32'h0);
      rc("drop", b + 12'h010, 32'h0);
      rc("count", b + 12'h014, 32'h0);
    end
    rc("base", 12'h00C, 32'h3);
    rd(12'h200);
    chk("unmapped", 32'h2, {d[29:0], rr});
    $display("test reset done");
    tgt[0] <= 19'h186A0;
    scans(2);
    chk("st0", 32'h1, 32'(st[0]));
    rc("count", 12'h054, 32'h1);
    rc("irq stat", 12'h004, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    wr(12'h008, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    wr(12'h004, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    rc("volt", 12'h058, 32'h186A0);
    tgt[0] <= 19'h11170;
    scans(2);
    chk("st0", 32'h1, 32'(st[0]));
    tgt[0] <= 19'h0C350;
    scans(2);
    chk("st0", 32'h0, 32'(st[0]));
    wr(12'h040, 32'h4);
    rc("count", 12'h054, 32'h0);
    rc("ctrl", 12'h040, 32'h0);
    $display("test open done");
    wr(12'h060, 32'h1);
    scans(2);
    chk("st1", 32'h1, 32'(st[1]));
    chk("st2", 32'h0, 32'(st[2]));
    tgt[1] <= 19'h186A0;
    scans(2);
    chk("st1", 32'h0, 32'(st[1]));
    $display("test closed done");
    wr(12'h08C, 32'hA);
    tgt[2] <= 19'h186A0;
    scans(2);
    chk("st2", 32'h0, 32'(st[2]));
    scans(2);
    chk("st2", 32'h1, 32'(st[2]));
    wr(12'h0AC, 32'h14);
    tgt[3] <= 19'h186A0;
    scans(2);
    tgt[3] <= 19'h0;
    scans(1);
    tgt[3] <= 19'h186A0;
    scans(4);
    chk("st3", 32'h0, 32'(st[3]));
    scans(2);
    chk("st3", 32'h1, 32'(st[3]));
    $display("test delay done");
    wr(12'h0C0, 32'h2);
    tgt[4] <= 19'h186A0;
    scans(2);
    tgt[4] <= 19'h0C350;
    scans(2);
    chk("st4", 32'h1, 32'(st[4]));
    tgt[4] <= 19'h01388;
    scans(6);
    chk("st4", 32'h1, 32'(st[4]));
    scans(2);
    chk("st4", 32'h0, 32'(st[4]));
    $display("test ac done");
    wr(12'h0F0, 32'hA);
    wr(12'h104, 32'h1F4);
    wr(12'h108, 32'hC8);
    tgt[5] <= 19'h186A0;
    tgt[6] <= 19'h11170;
    tgt[7] <= 19'h11170;
    pre <= 8'h0B;
    scans(2);
    chk("st5", 32'h1, 32'(st[5]));
    chk("st6", 32'h1, 32'(st[6]));
    chk("st7", 32'h0, 32'(st[7]));
    rc("base", 12'h00C, 32'hB);
    tgt[5] <= 19'h0;
    tgt[6] <= 19'h07530;
    scans(2);
    chk("st5", 32'h1, 32'(st[5]));
    chk("st6", 32'h1, 32'(st[6]));
    scans(2);
    chk("st5", 32'h0, 32'(st[5]));
    rc("off", 12'h108, 32'hC8);
    rc("off", 12'h0E8, 32'h258);
    $display("test settings done");
    give_verdict();
  end
endmodule

bind iic_top iic_props #(.SCAN_CYCLES(SCAN_CYCLES)) i_iic_props (.clk(clk), .resetn(resetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .channel_voltage_in(channel_voltage_in), .preceding_input_count(preceding_input_count),
  .channel_state(channel_state), .irq(irq));
